// *** pkg/weg_pkg.sv ***
// shared constants for the waveform event generator
package weg_pkg;

    // sample clock and pulse timing
    localparam int CLK_PERIOD_NS = 4;            // 250 MHz sample clock
    localparam int MIN_PULSE_NS = 150;           // narrowest marker or exported start pulse
    localparam logic [15:0] MIN_PULSE_CYC =
        16'((MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS); // rounded up
    localparam int START_LAT_MIN = 44;           // least start-to-output latency, cycles
    localparam logic [5:0] LAT_MIN = 6'(START_LAT_MIN);
    localparam logic [6:0] NS_ROUND = 7'h03;     // adds period-1 before dividing by 4 ns

    // alignment delay line
    localparam int DLY_DEPTH = 128;              // covers latency + event delay
    localparam int PTR_W = 7;
    localparam int LINE_W = 19;                  // data[15:0], marker, run, done
    localparam int LN_DONE = 0;
    localparam int LN_RUN = 1;
    localparam int LN_MARK = 2;
    localparam int LN_DATA = 3;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_MARK_POS = 8'h08;
    localparam logic [7:0] REG_WIDTH = 8'h0C;
    localparam logic [7:0] REG_DELAY = 8'h10;
    localparam logic [7:0] REG_BITSEL = 8'h14;
    localparam logic [7:0] REG_LATENCY = 8'h18;
    localparam logic [7:0] REG_ROUTE = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;

    // control bits
    localparam int CTRL_CONF = 0;                // configured, read/write
    localparam int CTRL_INIT = 1;                // initiate, write-only strobe
    localparam int CTRL_ABORT = 2;               // abort, write-only strobe

    // mode bits
    localparam int MODE_ST_PULSE = 0;            // started: 1 pulse, 0 level
    localparam int MODE_DN_PULSE = 1;            // done: 1 pulse, 0 level
    localparam int MODE_MK_TOGGLE = 2;           // marker: 1 toggle, 0 pulse
    localparam int MODE_MK_INIT = 3;             // toggle initial level
    localparam int MODE_POL_RDY = 4;             // level polarity, 1 = active high
    localparam int MODE_POL_ST = 5;
    localparam int MODE_POL_DN = 6;
    localparam logic [6:0] MODE_RST = 7'h70;

    // delay fields
    localparam int DLY_ST = 0;
    localparam int DLY_DN = 8;
    localparam int DLY_MK = 16;
    localparam int DLY_NS = 31;                  // 1 = fields hold nanoseconds

    // bit marker fields
    localparam int BSEL_INV = 16;                // four invert bits above four selects

    // status bits
    localparam int ST_RDY_LIVE = 0;
    localparam int ST_ST_LAT = 1;
    localparam int ST_DN_LAT = 2;
    localparam int ST_MK_LIVE = 3;
    localparam int ST_MK_LAT = 4;
    localparam int ST_FSM = 5;

    // terminal source codes
    localparam logic [3:0] ROUTE_OFF = 4'h0;
    localparam logic [3:0] ROUTE_LAST = 4'h9;    // 1 ready ... 5 out start, 6..9 bit markers

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b00,
        FSM_READY = 2'b01,
        FSM_RUN = 2'b10
    } weg_fsm_type;

endpackage

// *** verilog/weg_event_gen.sv ***
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - toggle mode flips output per event, preset level
// - pulse mode gives one timed pulse per event
// - level mode holds chosen polarity while active
// - live status shows present event condition
// - latched status sticks until cleared
// - ready level while configured and awaiting start
// - started event, level or pulse, latched
// - done event when waveform output finished
// - marker fires when chosen sample reaches output
// - marker fires again on every loop
// - marker aligned with output sample, no lag
// - marker pulse stretched to at least 150 ns
// - start to analog output at least 44 clocks
// - four bit markers, any of 16 bits
// - bit marker follows bit, optional inversion
// - bit markers aligned with output sample
// - events delayed whole clocks after analog output
// - delays in nanoseconds round up to periods
// - all terminals of one event share alignment
// - exported start fires at run entry, not delayed, 150 ns wide
module weg_event_gen
    import weg_pkg::*;
(
    input wire logic clk_sys_i,            // sample clock, 250 MHz
    input wire logic nrst_i,               // asynchronous reset, active low
    input wire logic psel_i,               // apb select
    input wire logic penable_i,            // apb access phase
    input wire logic pwrite_i,             // apb direction
    input wire logic [7:0] paddr_i,        // apb byte address
    input wire logic [31:0] pwdata_i,      // apb write data
    output logic [31:0] prdata_o,          // apb read data
    output logic pready_o,                 // apb ready, always high
    output logic pslverr_o,                // apb error on unmapped address
    input wire logic start_trig_i,         // start trigger pin, asynchronous
    input wire logic wfm_valid_i,          // waveform memory sample valid
    input wire logic [15:0] wfm_data_i,    // waveform sample
    input wire logic [15:0] wfm_index_i,   // sample index within waveform
    input wire logic wfm_end_i,            // last sample of the generation
    output logic fetch_en_o,               // waveform memory may stream
    output logic [15:0] dac_data_o,        // sample to primary_analog_output
    output logic front_terminal_a_o,       // routed event
    output logic front_terminal_b_o,       // routed event
    output logic aux_terminal_a_o,         // routed event, digital_data_connector
    output logic aux_terminal_b_o          // routed event, digital_data_connector
);

    // whole state of the block
    typedef struct packed {
        weg_fsm_type fsm;                  // generation sequencer
        logic conf;                        // software says configured
        logic [6:0] mode;                  // behaviours and polarities
        logic [15:0] mark_pos;             // marker sample index
        logic [15:0] width;                // pulse width, cycles
        logic [17:0] dly;                  // three 6-bit delays as written
        logic dly_ns;                      // delay unit is nanoseconds
        logic [19:0] bitsel;               // bit marker selects and inverts
        logic [5:0] lat;                   // analog path latency
        logic [15:0] route;                // four terminal sources
        logic [6:0] tap_st;                // delays frozen at initiate
        logic [6:0] tap_dn;
        logic [6:0] tap_mk;
        logic [5:0] tap_lat;
        logic [PTR_W-1:0] wr_ptr;          // delay line write pointer
        logic [2:0] sync;                  // start pin synchroniser and edge
        logic done_src;                    // generation finished
        logic t_run;                       // tapped run level
        logic t_run_d;
        logic t_done;                      // tapped done level
        logic t_done_d;
        logic t_mark;                      // tapped marker hit
        logic st_lat;                      // latched statuses
        logic dn_lat;
        logic mk_lat;
        logic mk_tgl;                      // toggle level
        logic [15:0] st_cnt;               // pulse stretchers
        logic [15:0] dn_cnt;
        logic [15:0] mk_cnt;
        logic [15:0] os_cnt;
        logic [15:0] dac;                  // output sample
        logic [3:0] bm;                    // bit marker levels
        logic [3:0] term;                  // terminal levels
        logic [31:0] prdata;               // read data
    } weg_regs_type;

    weg_regs_type s_r;
    weg_regs_type s_nxt;

    // alignment delay line, no reset needed: words are read only after latency fill
    logic [LINE_W-1:0] line_r [DLY_DEPTH];
    logic [LINE_W-1:0] line_in;
    logic [LINE_W-1:0] rd_st;
    logic [LINE_W-1:0] rd_dn;
    logic [LINE_W-1:0] rd_mk;
    logic [LINE_W-1:0] rd_dat;
    logic [LINE_W-1:0] rd_bm;

    // ns or cycles to whole cycles, rounding up
    function automatic logic [5:0] dly_cyc(input logic [5:0] v, input logic ns);
        logic [6:0] sum;
        sum = 7'(v) + NS_ROUND;
        dly_cyc = ns ? 6'(sum >> 2) : v;
    endfunction

    // tap distance: latency plus delay, minus the terminal register stage
    function automatic logic [6:0] tap_of(input logic [5:0] lat, input logic [5:0] d);
        tap_of = 7'(lat) + 7'(d) - 7'h01;
    endfunction

    // pulse stretcher: load on trigger, otherwise count down
    function automatic logic [15:0] stretch(input logic [15:0] cnt, input logic trig,
                                            input logic [15:0] w);
        if (trig) begin
            stretch = w - 16'h0001;
        end else if (cnt != 16'h0000) begin
            stretch = cnt - 16'h0001;
        end else begin
            stretch = 16'h0000;
        end
    endfunction

    // source code to event level
    function automatic logic pick(input logic [3:0] code, input logic [8:0] vec);
        logic [3:0] idx;
        idx = code - 4'h1;
        if (code == ROUTE_OFF || code > ROUTE_LAST) begin
            pick = 1'b0;
        end else begin
            pick = vec[idx];
        end
    endfunction

    // address decode for the error answer; the read path decodes on its own
    function automatic logic reg_hit(input logic [7:0] a);
        case (a)
            REG_CTRL, REG_MODE, REG_MARK_POS, REG_WIDTH, REG_DELAY,
            REG_BITSEL, REG_LATENCY, REG_ROUTE, REG_STATUS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // source word written each cycle, in fetch time
    always_comb begin
        line_in = '0;
        line_in[LN_RUN] = (s_r.fsm == FSM_RUN);
        line_in[LN_DONE] = s_r.done_src;
        // compare runs every sample so each loop of the waveform fires again
        line_in[LN_MARK] = (s_r.fsm == FSM_RUN) && wfm_valid_i &&
                           (wfm_index_i == s_r.mark_pos);
        line_in[LN_DATA +: 16] = wfm_valid_i ? wfm_data_i : 16'h0000;
    end

    // delay line write
    always_ff @(posedge clk_sys_i) begin
        line_r[s_r.wr_ptr] <= line_in;
    end

    // read ports: analog tap and per-event taps share one line, so all stay in step
    assign rd_dat = line_r[PTR_W'(s_r.wr_ptr - 7'(s_r.tap_lat))];
    assign rd_bm = line_r[PTR_W'(s_r.wr_ptr - tap_of(s_r.tap_lat, 6'h00))];
    assign rd_st = line_r[PTR_W'(s_r.wr_ptr - s_r.tap_st)];
    assign rd_dn = line_r[PTR_W'(s_r.wr_ptr - s_r.tap_dn)];
    assign rd_mk = line_r[PTR_W'(s_r.wr_ptr - s_r.tap_mk)];

    // next-state logic
    always_comb begin
        logic wr;
        logic rd_setup;
        logic start_edge;
        logic st_trig;
        logic dn_trig;
        logic [15:0] w_eff;
        logic [5:0] lat_eff;
        logic ev_rdy;
        logic ev_st;
        logic ev_dn;
        logic ev_mk;
        logic ev_os;
        logic [8:0] vec;
        wr = 1'b0;
        rd_setup = 1'b0;
        start_edge = 1'b0;
        st_trig = 1'b0;
        dn_trig = 1'b0;
        w_eff = 16'h0000;
        lat_eff = 6'h00;
        ev_rdy = 1'b0;
        ev_st = 1'b0;
        ev_dn = 1'b0;
        ev_mk = 1'b0;
        ev_os = 1'b0;
        vec = '0;
        s_nxt = s_r;

        wr = psel_i && penable_i && pwrite_i;
        rd_setup = psel_i && !penable_i && !pwrite_i;
        s_nxt.wr_ptr = s_r.wr_ptr + 7'h01;

        // start pin: the second and third stages feed the edge detector
        s_nxt.sync = {s_r.sync[1], s_r.sync[0], start_trig_i};
        start_edge = s_r.sync[1] && !s_r.sync[2];

        // the software width may be longer but never under the minimum
        w_eff = (s_r.width < MIN_PULSE_CYC) ? MIN_PULSE_CYC : s_r.width;
        lat_eff = (s_r.lat < LAT_MIN) ? LAT_MIN : s_r.lat;

        // tapped event bits, registered alongside the analog sample
        s_nxt.t_run = rd_st[LN_RUN];
        s_nxt.t_run_d = s_r.t_run;
        s_nxt.t_done = rd_dn[LN_DONE];
        s_nxt.t_done_d = s_r.t_done;
        s_nxt.t_mark = rd_mk[LN_MARK];
        s_nxt.dac = rd_dat[LN_DATA +: 16];

        // bit markers, one stage early so the terminal register lines them up
        for (int i = 0; i < 4; i++) begin
            s_nxt.bm[i] = rd_bm[LN_DATA + int'(s_r.bitsel[4*i +: 4])] ^
                          s_r.bitsel[BSEL_INV + i];
        end

        st_trig = s_r.t_run && !s_r.t_run_d;
        dn_trig = s_r.t_done && !s_r.t_done_d;

        // register writes
        if (wr) begin
            case (paddr_i)
                REG_CTRL: s_nxt.conf = pwdata_i[CTRL_CONF];
                REG_MODE: s_nxt.mode = pwdata_i[6:0];
                REG_MARK_POS: s_nxt.mark_pos = pwdata_i[15:0];
                REG_WIDTH: s_nxt.width = pwdata_i[15:0];
                REG_DELAY: begin
                    s_nxt.dly = {pwdata_i[DLY_MK +: 6], pwdata_i[DLY_DN +: 6],
                                 pwdata_i[DLY_ST +: 6]};
                    s_nxt.dly_ns = pwdata_i[DLY_NS];
                end
                REG_BITSEL: s_nxt.bitsel = pwdata_i[19:0];
                REG_LATENCY: s_nxt.lat = pwdata_i[5:0];
                REG_ROUTE: s_nxt.route = pwdata_i[15:0];
                default: begin
                end
            endcase
        end

        // sequencer
        case (s_r.fsm)
            FSM_IDLE: begin
                if (wr && paddr_i == REG_CTRL && pwdata_i[CTRL_INIT] && s_nxt.conf) begin
                    s_nxt.fsm = FSM_READY;
                    s_nxt.done_src = 1'b0;
                    // freeze delays now; later writes wait for the next initiate
                    s_nxt.tap_lat = lat_eff;
                    s_nxt.tap_st = tap_of(lat_eff,
                                          dly_cyc(s_r.dly[5:0], s_r.dly_ns));
                    s_nxt.tap_dn = tap_of(lat_eff,
                                          dly_cyc(s_r.dly[11:6], s_r.dly_ns));
                    s_nxt.tap_mk = tap_of(lat_eff,
                                          dly_cyc(s_r.dly[17:12], s_r.dly_ns));
                    s_nxt.st_lat = 1'b0;
                    s_nxt.dn_lat = 1'b0;
                    s_nxt.mk_lat = 1'b0;
                    s_nxt.mk_tgl = s_r.mode[MODE_MK_INIT];
                end
            end
            FSM_READY: begin
                if (!s_r.conf) begin
                    s_nxt.fsm = FSM_IDLE;
                end else if (start_edge) begin
                    s_nxt.fsm = FSM_RUN;
                    s_nxt.os_cnt = MIN_PULSE_CYC;
                end
            end
            FSM_RUN: begin
                if (wfm_valid_i && wfm_end_i) begin
                    s_nxt.fsm = FSM_IDLE;
                    s_nxt.done_src = 1'b1;
                end
            end
            default: s_nxt.fsm = FSM_IDLE;
        endcase
        if (wr && paddr_i == REG_CTRL && pwdata_i[CTRL_ABORT]) begin
            s_nxt.fsm = FSM_IDLE;
        end
        if (!(s_r.fsm == FSM_READY && start_edge) && s_r.os_cnt != 16'h0000) begin
            s_nxt.os_cnt = s_r.os_cnt - 16'h0001;
        end

        // status clear by writing ones
        if (wr && paddr_i == REG_STATUS) begin
            if (pwdata_i[ST_ST_LAT]) begin
                s_nxt.st_lat = 1'b0;
            end
            if (pwdata_i[ST_DN_LAT]) begin
                s_nxt.dn_lat = 1'b0;
            end
            if (pwdata_i[ST_MK_LAT]) begin
                s_nxt.mk_lat = 1'b0;
            end
        end
        // sets come last so an event in the clearing cycle survives
        if (st_trig) begin
            s_nxt.st_lat = 1'b1;
        end
        if (dn_trig) begin
            s_nxt.dn_lat = 1'b1;
        end
        if (s_r.t_mark) begin
            s_nxt.mk_lat = 1'b1;
            s_nxt.mk_tgl = !s_r.mk_tgl;
        end

        // pulse stretchers
        s_nxt.st_cnt = stretch(s_r.st_cnt, st_trig, w_eff);
        s_nxt.dn_cnt = stretch(s_r.dn_cnt, dn_trig, w_eff);
        s_nxt.mk_cnt = stretch(s_r.mk_cnt, s_r.t_mark, w_eff);

        // event levels
        ev_rdy = (s_r.fsm == FSM_READY) ~^ s_r.mode[MODE_POL_RDY];
        ev_st = s_r.mode[MODE_ST_PULSE] ? (st_trig || s_r.st_cnt != 16'h0000)
                                        : (s_r.t_run ~^ s_r.mode[MODE_POL_ST]);
        ev_dn = s_r.mode[MODE_DN_PULSE] ? (dn_trig || s_r.dn_cnt != 16'h0000)
                                        : (s_r.t_done ~^ s_r.mode[MODE_POL_DN]);
        // toggle shows the flip in the hit cycle itself, before the register follows
        ev_mk = s_r.mode[MODE_MK_TOGGLE] ? (s_r.mk_tgl ^ s_r.t_mark)
                                         : (s_r.t_mark || s_r.mk_cnt != 16'h0000);
        ev_os = (s_r.os_cnt != 16'h0000);
        vec = {s_r.bm, ev_os, ev_mk, ev_dn, ev_st, ev_rdy};

        // one shared source per event: every terminal sees the same edge
        for (int k = 0; k < 4; k++) begin
            s_nxt.term[k] = pick(s_r.route[4*k +: 4], vec);
        end

        // read data captured in the setup cycle, shown in the access cycle
        if (rd_setup) begin
            case (paddr_i)
                REG_CTRL: s_nxt.prdata = {31'h0000_0000, s_r.conf};
                REG_MODE: s_nxt.prdata = {25'h000_0000, s_r.mode};
                REG_MARK_POS: s_nxt.prdata = {16'h0000, s_r.mark_pos};
                REG_WIDTH: s_nxt.prdata = {16'h0000, s_r.width};
                REG_DELAY: s_nxt.prdata = {s_r.dly_ns, 9'h000, s_r.dly[17:12], 2'h0,
                                           s_r.dly[11:6], 2'h0, s_r.dly[5:0]};
                REG_BITSEL: s_nxt.prdata = {12'h000, s_r.bitsel};
                REG_LATENCY: s_nxt.prdata = {26'h000_0000, s_r.lat};
                REG_ROUTE: s_nxt.prdata = {16'h0000, s_r.route};
                REG_STATUS: s_nxt.prdata = {25'h000_0000, s_r.fsm, s_r.mk_lat,
                                            s_r.t_mark, s_r.dn_lat, s_r.st_lat,
                                            (s_r.fsm == FSM_READY)};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
            s_r.mode <= MODE_RST;
            s_r.width <= MIN_PULSE_CYC;
            s_r.lat <= LAT_MIN;
            s_r.tap_lat <= LAT_MIN;
            s_r.tap_st <= 7'(LAT_MIN) - 7'h01;
            s_r.tap_dn <= 7'(LAT_MIN) - 7'h01;
            s_r.tap_mk <= 7'(LAT_MIN) - 7'h01;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign prdata_o = s_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !reg_hit(paddr_i);
    assign fetch_en_o = (s_r.fsm == FSM_RUN);
    assign dac_data_o = s_r.dac;
    assign front_terminal_a_o = s_r.term[0];
    assign front_terminal_b_o = s_r.term[1];
    assign aux_terminal_a_o = s_r.term[2];
    assign aux_terminal_b_o = s_r.term[3];

endmodule
`default_nettype wire

// *** tb/weg_event_gen_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module weg_event_gen_properties
    import weg_pkg::*;
(
    input wire logic clk_sys_i, // sample clock
    input wire logic nrst_i, // reset, active low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb access
    input wire logic pwrite_i, // apb direction
    input wire logic [7:0] paddr_i, // apb address
    input wire logic [31:0] pwdata_i, // apb write data
    input wire logic [31:0] prdata_o, // apb read data
    input wire logic pready_o, // apb ready
    input wire logic pslverr_o, // apb error
    input wire logic start_trig_i, // start pin
    input wire logic wfm_valid_i, // sample valid
    input wire logic [15:0] wfm_data_i, // sample
    input wire logic fetch_en_o, // running
    input wire logic [15:0] dac_data_o, // output sample
    input wire logic front_terminal_a_o // routed event
);
    logic wr_w; // write completes this edge
    logic [3:0] route_a_r; // shadow of terminal a source
    logic mk_tog_r; // shadow of marker toggle mode
    logic [15:0] hi_cnt_r; // high run length of terminal a
    assign wr_w = psel_i && penable_i && pwrite_i;
    // shadows let the width check know when terminal a carries a pulse
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            route_a_r <= 4'h0;
            mk_tog_r <= 1'b0;
            hi_cnt_r <= 16'h0000;
        end else begin
            if (wr_w && paddr_i == REG_ROUTE) route_a_r <= pwdata_i[3:0];
            if (wr_w && paddr_i == REG_MODE) mk_tog_r <= pwdata_i[MODE_MK_TOGGLE];
            hi_cnt_r <= front_terminal_a_o ? hi_cnt_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    pready_high_a: assert property (pready_o) else $error("pready low");
    err_access_a: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray error");
    unmapped_zero_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i > 8'h20
        |-> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped read");
    mapped_ok_a: assert property (psel_i && penable_i && paddr_i <= 8'h20
        && paddr_i[1:0] == 2'b00 |-> !pslverr_o) else $error("mapped error");
    abort_stop_a: assert property (wr_w && paddr_i == REG_CTRL && pwdata_i[CTRL_ABORT]
        |=> !fetch_en_o) else $error("abort ignored");
    start_cause_a: assert property ($rose(fetch_en_o) |-> $past(start_trig_i, 2)
        || $past(start_trig_i, 3) || $past(start_trig_i, 4)) else $error("no start");
    dac_latency_a: assert property (fetch_en_o && wfm_valid_i
        |-> ##45 dac_data_o == $past(wfm_data_i, 45)) else $error("dac latency");
    marker_width_a: assert property ($fell(front_terminal_a_o) && route_a_r == 4'h4
        && !mk_tog_r |-> hi_cnt_r >= MIN_PULSE_CYC) else $error("short pulse");
    cover property ($rose(fetch_en_o));
    cover property ($fell(front_terminal_a_o) && route_a_r == 4'h4);
    cover property (pslverr_o);
endmodule
bind weg_event_gen weg_event_gen_properties i_props (.*);
`default_nettype wire

// *** tb/weg_evt_rx.sv ***
`timescale 1ns/1ns
`default_nettype none
// receiving instrument: counts trigger edges, measures the last pulse
module weg_evt_rx (
    input wire logic clk_i, // sample clock
    input wire logic evt_i, // exported event line
    output int rises_o, // rising edges seen
    output int width_o // last pulse width, cycles
);
    int rises = 0; // edge count
    int width = 0; // last width
    int run = 0; // current high run
    logic prev = 1'b0; // previous level
    assign rises_o = rises;
    assign width_o = width;
    // an unknown level never counts as a trigger
    always @(posedge clk_i) begin
        if (evt_i === 1'b1 && prev !== 1'b1) rises++;
        if (evt_i === 1'b1) run++;
        else if (run > 0) begin
            width = run;
            run = 0;
        end
        prev = evt_i;
    end
endmodule
`default_nettype wire

// *** tb/weg_event_gen_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module weg_event_gen_tb;
    import weg_pkg::*;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, start_trig_i = 1'b0, wfm_valid_i = 1'b0, wfm_end_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [15:0] wfm_data_i = 16'h0000, wfm_index_i = 16'h0000;
    wire logic [31:0] prdata_o;
    wire logic [15:0] dac_data_o;
    wire logic pready_o, pslverr_o, fetch_en_o, front_terminal_a_o, front_terminal_b_o;
    wire logic aux_terminal_a_o, aux_terminal_b_o;
    int miscompares = 0, compares = 0, rises, width, pcnt = 0, i, md = 0;
    logic [31:0] rd;
    logic er, mon_on = 1'b0, tm = 1'b0, tg = 1'b0; // tm: marker in toggle mode, tg its level
    logic [7:0] hs = 8'h00; // recent marker hits, index md is the delayed one
    logic [3:0] bsel = 4'h0;
    logic [17:0] hq[$]; // marker hit, valid, sample per cycle
    logic [17:0] e;
    always #2 clk_sys_i = ~clk_sys_i;
    weg_event_gen i_weg_event_gen (.*);
    weg_evt_rx i_weg_evt_rx (.clk_i(clk_sys_i), .evt_i(front_terminal_a_o),
        .rises_o(rises), .width_o(width));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, x);
    endtask
    // reference pipeline: everything shows 45 cycles after the sample edge, the marker md cycles later
    always @(posedge clk_sys_i) begin
        hq.push_back({wfm_valid_i && wfm_index_i == 16'h0005, wfm_valid_i,
            wfm_valid_i ? wfm_data_i : 16'h0000});
        if (hq.size() > 45) begin
            e = hq.pop_front();
            hs = {hs[6:0], e[17]};
            if (hs[md]) begin
                pcnt = 38;
                tg = !tg;
            end
            if (mon_on) begin
                chk(32'(dac_data_o), 32'(e[15:0]));
                chk(32'(front_terminal_a_o), 32'(tm ? tg : pcnt > 0));
                chk(32'(aux_terminal_b_o), 32'(e[bsel]));
            end
            if (pcnt > 0) pcnt--;
        end
    end
    task start_run;
        start_trig_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        start_trig_i <= 1'b0;
        for (i = 0; i < 20 && fetch_en_o !== 1'b1; i++) @(posedge clk_sys_i);
    endtask
    // n samples in loops of 50, marker at index 5 of each; fin ends the generation
    task stream(input int n, input logic fin);
        for (i = 0; i < n; i++) begin
            wfm_valid_i <= 1'b1;
            wfm_data_i <= 16'($urandom);
            wfm_index_i <= 16'(i % 50);
            wfm_end_i <= fin && (i == n - 1);
            @(posedge clk_sys_i);
            if (i == 60) chk(32'(front_terminal_b_o), 32'h0000_0001);
        end
        wfm_valid_i <= 1'b0;
        wfm_end_i <= 1'b0;
        repeat (60) @(posedge clk_sys_i);
    endtask
    initial begin
        rd = $urandom(32'ha74b);
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (130) @(posedge clk_sys_i);
        rdchk(REG_MODE, 32'h0000_007F, 32'h0000_0070);
        rdchk(REG_WIDTH, 32'h0000_FFFF, 32'h0000_0026);
        rdchk(REG_STATUS, 32'h0000_007F, 32'h0000_0000);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        bsel = 4'($urandom_range(15));
        apb(1'b1, REG_BITSEL, {28'h000_0000, bsel});
        apb(1'b1, REG_ROUTE, 32'h0000_6124);
        apb(1'b1, REG_MARK_POS, 32'h0000_0005);
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        mon_on = 1'b1;
        rdchk(REG_STATUS, 32'h0000_007F, 32'h0000_0021);
        chk(32'(aux_terminal_a_o), 32'h0000_0001);
        start_run();
        stream(100, 1'b1);
        chk(rises, 2);
        chk(width, 38);
        rdchk(REG_STATUS, 32'h0000_0017, 32'h0000_0016);
        // second run: marker toggles from level 1, delayed 5 ns, i.e. two whole clocks
        apb(1'b1, REG_MODE, 32'h0000_007C);
        apb(1'b1, REG_DELAY, 32'h8005_0000);
        md = 2;
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        tm <= 1'b1;
        tg <= 1'b1;
        rdchk(REG_STATUS, 32'h0000_0016, 32'h0000_0000);
        apb(1'b1, REG_DELAY, 32'h0000_0000);
        start_run();
        stream(100, 1'b0);
        chk(rises, 4);
        apb(1'b1, REG_CTRL, 32'h0000_0005);
        chk(32'(fetch_en_o), 32'h0000_0000);
        end_of_test();
    end
    // hang guard, far beyond the expected run length
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
